// ===== rtl/alarm_offset_command_logic.sv
// Command actions, offset calibration registers and dual alarm monitors
`timescale 1ns/1ns
`default_nettype none
`include "alarm_offset_consts.svh"

module alarm_offset_command_logic
  import alarm_offset_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = `FLASH_CYCLES
)(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        sample_valid_i,
  input  wire sample_t     out_data_i,
  input  wire sample_t     raw_data_i,
  input  wire logic        flash_fail_i,
  output offsets_t         offsets_o,
  output logic [11:0]      dac_level_o,
  output logic             flash_busy_o,
  output logic             flash_commit_o,
  output flash_image_t     flash_image_o,
  output logic             aux_line_one_o,
  output logic             aux_line_one_oe_o,
  output logic             aux_line_two_o,
  output logic             aux_line_two_oe_o
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------
  // Register file and command decode
  // ---------------------------------------------------------------
  offsets_t     offs_reg, offs_next;
  logic [15:0]  thresh1_reg, thresh1_next;
  logic [15:0]  thresh2_reg, thresh2_next;
  logic [7:0]   count1_reg, count1_next;
  logic [7:0]   count2_reg, count2_next;
  logic [15:0]  ctrl_reg, ctrl_next;
  logic [11:0]  dac_reg, dac_next;
  logic [11:0]  dac_out_reg, dac_out_next;
  logic         flash_err_reg, flash_err_next;
  logic         alm1_st_reg, alm1_st_next;
  logic         alm2_st_reg, alm2_st_next;
  logic [15:0]  rdata_reg, rdata_next;
  logic         rvalid_reg, rvalid_next;

  logic         hi;
  logic [5:0]   waddr;
  logic [7:0]   cmd;
  logic         status_read;
  logic         flash_fail_set;
  logic         alm1_active;
  logic         alm2_active;

  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic upper,
                                           input logic [7:0] b);
    return upper ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  function automatic logic [13:0] negate(input logic [13:0] v);
    return ~v + 14'h0001;
  endfunction

  always_comb begin
    hi    = reg_addr_i[0];
    waddr = {reg_addr_i[5:1], 1'b0};
    cmd   = (reg_wr_i && waddr == `ADDR_COMMAND && !hi) ? reg_wdata_i : 8'h00;
    status_read = reg_rd_i && waddr == `ADDR_STATUS;

    offs_next    = offs_reg;
    thresh1_next = thresh1_reg;
    thresh2_next = thresh2_reg;
    count1_next  = count1_reg;
    count2_next  = count2_reg;
    ctrl_next    = ctrl_reg;
    dac_next     = dac_reg;
    dac_out_next = dac_out_reg;

    if (reg_wr_i) begin
      unique case (waddr)
        `ADDR_X_ACCEL_OFF: offs_next.x_accel = 14'(put_byte({2'b00, offs_reg.x_accel}, hi,
                                                            reg_wdata_i));
        `ADDR_Y_ACCEL_OFF: offs_next.y_accel = 14'(put_byte({2'b00, offs_reg.y_accel}, hi,
                                                            reg_wdata_i));
        `ADDR_X_INCL_OFF:  offs_next.x_incl = 14'(put_byte({2'b00, offs_reg.x_incl}, hi,
                                                           reg_wdata_i));
        `ADDR_Y_INCL_OFF:  offs_next.y_incl = 14'(put_byte({2'b00, offs_reg.y_incl}, hi,
                                                           reg_wdata_i));
        `ADDR_ROT_OFF:     offs_next.rot = 14'(put_byte({2'b00, offs_reg.rot}, hi,
                                                        reg_wdata_i));
        `ADDR_ALM1_THRESH: thresh1_next = put_byte(thresh1_reg, hi, reg_wdata_i)
                                          & 16'hBFFF;
        `ADDR_ALM2_THRESH: thresh2_next = put_byte(thresh2_reg, hi, reg_wdata_i)
                                          & 16'hBFFF;
        `ADDR_ALM1_COUNT:  count1_next = hi ? count1_reg : reg_wdata_i;
        `ADDR_ALM2_COUNT:  count2_next = hi ? count2_reg : reg_wdata_i;
        `ADDR_ALARM_CONTROL:    ctrl_next = put_byte(ctrl_reg, hi, reg_wdata_i) & 16'hFF7F;
        `ADDR_AUX_DAC:     dac_next = 12'(put_byte({4'h0, dac_reg}, hi, reg_wdata_i));
        default: begin
        end
      endcase
    end

    if (cmd[`CMD_RESTORE]) begin
      offs_next = '0;
    end
    if (cmd[`CMD_AUTONULL]) begin
      offs_next.x_accel = negate(out_data_i.x_accel);
      offs_next.y_accel = negate(out_data_i.y_accel);
      offs_next.x_incl  = negate(out_data_i.x_incl);
      offs_next.y_incl  = negate(out_data_i.y_incl);
      offs_next.rot     = negate(out_data_i.rot);
    end
    if (cmd[`CMD_DAC_LATCH]) begin
      dac_out_next = dac_reg;
    end

    // Hardware set wins over read or command clear
    flash_err_next = (flash_err_reg & ~(status_read | cmd[`CMD_STATUS_CLR]))
                     | flash_fail_set;
    alm1_st_next   = (alm1_st_reg & ~cmd[`CMD_STATUS_CLR]) | alm1_active;
    alm2_st_next   = (alm2_st_reg & ~cmd[`CMD_STATUS_CLR]) | alm2_active;

    rvalid_next = reg_rd_i;
    rdata_next  = rdata_reg;
    if (reg_rd_i) begin
      unique case (waddr)
        `ADDR_X_ACCEL_OFF: rdata_next = {2'b00, offs_reg.x_accel};
        `ADDR_Y_ACCEL_OFF: rdata_next = {2'b00, offs_reg.y_accel};
        `ADDR_X_INCL_OFF:  rdata_next = {2'b00, offs_reg.x_incl};
        `ADDR_Y_INCL_OFF:  rdata_next = {2'b00, offs_reg.y_incl};
        `ADDR_ROT_OFF:     rdata_next = {2'b00, offs_reg.rot};
        `ADDR_ALM1_THRESH: rdata_next = thresh1_reg;
        `ADDR_ALM2_THRESH: rdata_next = thresh2_reg;
        `ADDR_ALM1_COUNT:  rdata_next = {8'h00, count1_reg};
        `ADDR_ALM2_COUNT:  rdata_next = {8'h00, count2_reg};
        `ADDR_ALARM_CONTROL:    rdata_next = ctrl_reg;
        `ADDR_AUX_DAC:     rdata_next = {4'h0, dac_reg};
        `ADDR_STATUS:      rdata_next = {6'h00, alm2_st_reg, alm1_st_reg, 5'h00,
                                         flash_err_reg, 2'b00};
        default:           rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      offs_reg      <= {5{`RST_OFFSET}};
      thresh1_reg   <= `RST_THRESH;
      thresh2_reg   <= `RST_THRESH;
      count1_reg    <= `RST_COUNT;
      count2_reg    <= `RST_COUNT;
      ctrl_reg      <= `RST_ALARM_CONTROL;
      dac_reg       <= `RST_AUX_DAC;
      dac_out_reg   <= `RST_AUX_DAC;
      flash_err_reg <= 1'b0;
      alm1_st_reg   <= 1'b0;
      alm2_st_reg   <= 1'b0;
      rdata_reg     <= 16'h0000;
      rvalid_reg    <= 1'b0;
    end else begin
      offs_reg      <= offs_next;
      thresh1_reg   <= thresh1_next;
      thresh2_reg   <= thresh2_next;
      count1_reg    <= count1_next;
      count2_reg    <= count2_next;
      ctrl_reg      <= ctrl_next;
      dac_reg       <= dac_next;
      dac_out_reg   <= dac_out_next;
      flash_err_reg <= flash_err_next;
      alm1_st_reg   <= alm1_st_next;
      alm2_st_reg   <= alm2_st_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
    end
  end

  // ---------------------------------------------------------------
  // Flash backup sequencer
  // ---------------------------------------------------------------
  flash_state_t fl_state_reg, fl_state_next;
  logic [21:0]  fl_cnt_reg, fl_cnt_next;
  logic         fl_fail_reg, fl_fail_next;
  logic         commit_reg, commit_next;
  flash_image_t image_reg, image_next;

  always_comb begin
    fl_state_next  = fl_state_reg;
    fl_cnt_next    = fl_cnt_reg;
    fl_fail_next   = fl_fail_reg;
    image_next     = image_reg;
    commit_next    = 1'b0;
    flash_fail_set = 1'b0;
    unique case (fl_state_reg)
      FL_IDLE: begin
        // Pending error locks out flash access until cleared
        if (cmd[`CMD_FLASH] && !flash_err_reg) begin
          fl_state_next = FL_BUSY;
          fl_cnt_next   = 22'h000000;
          fl_fail_next  = 1'b0;
          image_next    = {offs_reg, thresh1_reg, thresh2_reg, count1_reg, count2_reg,
                           ctrl_reg};
        end
      end
      FL_BUSY: begin
        fl_fail_next = fl_fail_reg | flash_fail_i;
        if (fl_cnt_reg == 22'(FLASH_CYCLES - 1)) begin
          fl_state_next  = FL_IDLE;
          commit_next    = 1'b1;
          flash_fail_set = fl_fail_reg | flash_fail_i;
        end else begin
          fl_cnt_next = fl_cnt_reg + 22'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fl_state_reg <= FL_IDLE;
      fl_cnt_reg   <= 22'h000000;
      fl_fail_reg  <= 1'b0;
      commit_reg   <= 1'b0;
      image_reg    <= '0;
    end else begin
      fl_state_reg <= fl_state_next;
      fl_cnt_reg   <= fl_cnt_next;
      fl_fail_reg  <= fl_fail_next;
      commit_reg   <= commit_next;
      image_reg    <= image_next;
    end
  end

  // ---------------------------------------------------------------
  // Alarm source selection and monitors
  // ---------------------------------------------------------------
  alarm_cfg_t  cfg1, cfg2;
  logic [13:0] val1, val2;

  function automatic logic [13:0] pick(input logic [3:0] code, input logic filt,
                                       input sample_t raw, input sample_t out);
    sample_t s;
    s = (filt || code == `SRC_X_INCL || code == `SRC_Y_INCL || code == `SRC_ROT)
        ? out : raw;
    unique case (code)
      `SRC_SUPPLY:  return s.supply;
      `SRC_X_ACCEL: return s.x_accel;
      `SRC_Y_ACCEL: return s.y_accel;
      `SRC_AUX_ADC: return s.aux_adc;
      `SRC_TEMP:    return s.temp;
      `SRC_X_INCL:  return s.x_incl;
      `SRC_Y_INCL:  return s.y_incl;
      `SRC_ROT:     return s.rot;
      default:      return 14'h0000;
    endcase
  endfunction

  always_comb begin
    cfg1.enable = ctrl_reg[`CTL_ALM1_SRC_HI:`CTL_ALM1_SRC_LO] != `SRC_DISABLED &&
                  ctrl_reg[`CTL_ALM1_SRC_HI:`CTL_ALM1_SRC_LO] <= `SRC_ROT;
    cfg1.roc    = ctrl_reg[`CTL_ALM1_ROC];
    cfg1.gt     = thresh1_reg[`THRESH_GT_BIT];
    cfg1.mag    = thresh1_reg[13:0];
    cfg1.count  = count1_reg;
    cfg2.enable = ctrl_reg[`CTL_ALM2_SRC_HI:`CTL_ALM2_SRC_LO] != `SRC_DISABLED &&
                  ctrl_reg[`CTL_ALM2_SRC_HI:`CTL_ALM2_SRC_LO] <= `SRC_ROT;
    cfg2.roc    = ctrl_reg[`CTL_ALM2_ROC];
    cfg2.gt     = thresh2_reg[`THRESH_GT_BIT];
    cfg2.mag    = thresh2_reg[13:0];
    cfg2.count  = count2_reg;
    val1 = pick(ctrl_reg[`CTL_ALM1_SRC_HI:`CTL_ALM1_SRC_LO], ctrl_reg[`CTL_ALM1_FILT],
                raw_data_i, out_data_i);
    val2 = pick(ctrl_reg[`CTL_ALM2_SRC_HI:`CTL_ALM2_SRC_LO], ctrl_reg[`CTL_ALM2_FILT],
                raw_data_i, out_data_i);
  end

  alarm_monitor u_alarm_one (
    .clock_i        (clock_i),
    .rst_n_i        (rst_n),
    .sample_valid_i (sample_valid_i),
    .value_i        (val1),
    .cfg_i          (cfg1),
    .active_o       (alm1_active)
  );

  alarm_monitor u_alarm_two (
    .clock_i        (clock_i),
    .rst_n_i        (rst_n),
    .sample_valid_i (sample_valid_i),
    .value_i        (val2),
    .cfg_i          (cfg2),
    .active_o       (alm2_active)
  );

  // ---------------------------------------------------------------
  // Alarm indicator lines
  // ---------------------------------------------------------------
  logic [3:0] line_reg, line_next;
  logic       ind;

  always_comb begin
    ind       = (alm1_active | alm2_active) ~^ ctrl_reg[`CTL_IND_POL];
    line_next = 4'h0;
    if (ctrl_reg[`CTL_IND_EN]) begin
      line_next = ctrl_reg[`CTL_IND_LINE] ? {ind, 1'b1, 2'b00} : {2'b00, ind, 1'b1};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      line_reg <= 4'h0;
    end else begin
      line_reg <= line_next;
    end
  end

  assign reg_rdata_o       = rdata_reg;
  assign reg_rvalid_o      = rvalid_reg;
  assign offsets_o         = offs_reg;
  assign dac_level_o       = dac_out_reg;
  assign flash_busy_o      = (fl_state_reg == FL_BUSY);
  assign flash_commit_o    = commit_reg;
  assign flash_image_o     = image_reg;
  assign aux_line_two_o    = line_reg[3];
  assign aux_line_two_oe_o = line_reg[2];
  assign aux_line_one_o    = line_reg[1];
  assign aux_line_one_oe_o = line_reg[0];

endmodule

`default_nettype wire

// ===== rtl/alarm_offset_consts.svh
// Register offsets, field positions, reset values and timing for the command/alarm block
`ifndef ALARM_OFFSET_CONSTS_SVH
`define ALARM_OFFSET_CONSTS_SVH

// Byte addresses of the 16-bit registers (low byte even, high byte odd)
`define ADDR_X_ACCEL_OFF   6'h10
`define ADDR_Y_ACCEL_OFF   6'h12
`define ADDR_X_INCL_OFF    6'h14
`define ADDR_Y_INCL_OFF    6'h16
`define ADDR_ROT_OFF       6'h18
`define ADDR_ALM1_THRESH   6'h20
`define ADDR_ALM2_THRESH   6'h22
`define ADDR_ALM1_COUNT    6'h24
`define ADDR_ALM2_COUNT    6'h26
`define ADDR_ALARM_CONTROL      6'h28
`define ADDR_AUX_DAC       6'h30
`define ADDR_STATUS        6'h3C
`define ADDR_COMMAND       6'h3E

// Command bits
`define CMD_AUTONULL       0
`define CMD_RESTORE        1
`define CMD_DAC_LATCH      2
`define CMD_FLASH          3
`define CMD_STATUS_CLR     4

// Status bits
`define ST_FLASH_ERR       2
`define ST_ALM1            8
`define ST_ALM2            9

// Alarm control fields and threshold comparison bit
`define CTL_ALM2_SRC_HI    15
`define CTL_ALM2_SRC_LO    12
`define CTL_ALM1_SRC_HI    11
`define CTL_ALM1_SRC_LO    8
`define CTL_ALM2_ROC       6
`define CTL_ALM1_ROC       5
`define CTL_ALM2_FILT      4
`define CTL_ALM1_FILT      3
`define CTL_IND_EN         2
`define CTL_IND_POL        1
`define CTL_IND_LINE       0
`define THRESH_GT_BIT      15

// Alarm source codes
`define SRC_DISABLED       4'h0
`define SRC_SUPPLY         4'h1
`define SRC_X_ACCEL        4'h2
`define SRC_Y_ACCEL        4'h3
`define SRC_AUX_ADC        4'h4
`define SRC_TEMP           4'h5
`define SRC_X_INCL         4'h6
`define SRC_Y_INCL         4'h7
`define SRC_ROT            4'h8

// Reset values
`define RST_OFFSET         14'h0000
`define RST_THRESH         16'h0000
`define RST_COUNT          8'h01
`define RST_ALARM_CONTROL       16'h0000
`define RST_AUX_DAC        12'h000

// Timing
`define CLK_HZ             50000000
`define FLASH_TIME_MS      50
`define FLASH_CYCLES       (`FLASH_TIME_MS * (`CLK_HZ / 1000))

`endif

// ===== rtl/alarm_offset_pkg.sv
// Types shared by the command/alarm block
package alarm_offset_pkg;

  typedef struct packed {
    logic [13:0] supply;
    logic [13:0] x_accel;
    logic [13:0] y_accel;
    logic [13:0] aux_adc;
    logic [13:0] temp;
    logic [13:0] x_incl;
    logic [13:0] y_incl;
    logic [13:0] rot;
  } sample_t;

  typedef struct packed {
    logic [13:0] x_accel;
    logic [13:0] y_accel;
    logic [13:0] x_incl;
    logic [13:0] y_incl;
    logic [13:0] rot;
  } offsets_t;

  typedef struct packed {
    logic        enable;
    logic        roc;
    logic        gt;
    logic [13:0] mag;
    logic [7:0]  count;
  } alarm_cfg_t;

  typedef struct packed {
    offsets_t    offs;
    logic [15:0] thresh1;
    logic [15:0] thresh2;
    logic [7:0]  count1;
    logic [7:0]  count2;
    logic [15:0] ctrl;
  } flash_image_t;

  typedef enum logic {FL_IDLE, FL_BUSY} flash_state_t;

endpackage

// ===== rtl/alarm_monitor.sv
// One alarm monitor: static threshold or averaged rate-of-change comparison
`timescale 1ns/1ns
`default_nettype none

module alarm_monitor
  import alarm_offset_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        sample_valid_i,
  input  wire logic [13:0] value_i,
  input  wire alarm_cfg_t  cfg_i,
  output logic             active_o
);

  logic [13:0]        prev_reg, prev_next;
  logic               primed_reg, primed_next;
  logic signed [23:0] acc_reg, acc_next;
  logic [7:0]         n_reg, n_next;
  logic               active_reg, active_next;

  logic [7:0]         n_target;
  logic signed [14:0] diff;
  logic signed [23:0] acc_sum;
  logic signed [23:0] limit;

  always_comb begin
    n_target = (cfg_i.count == 8'h00) ? 8'h01 : cfg_i.count;
    diff     = $signed({value_i[13], value_i}) - $signed({prev_reg[13], prev_reg});
    acc_sum  = acc_reg + 24'(diff);
    limit    = 24'($signed(cfg_i.mag)) * $signed({16'h0000, n_target});
    prev_next   = prev_reg;
    primed_next = primed_reg;
    acc_next    = acc_reg;
    n_next      = n_reg;
    active_next = active_reg;
    if (!cfg_i.enable) begin
      primed_next = 1'b0;
      acc_next    = 24'h000000;
      n_next      = 8'h00;
      active_next = 1'b0;
    end else if (sample_valid_i) begin
      prev_next   = value_i;
      primed_next = 1'b1;
      if (!cfg_i.roc) begin
        acc_next    = 24'h000000;
        n_next      = 8'h00;
        active_next = cfg_i.gt ? ($signed(value_i) > $signed(cfg_i.mag))
                               : ($signed(value_i) < $signed(cfg_i.mag));
      end else if (primed_reg) begin
        // Sum of differences against magnitude times count avoids a divider
        if (n_reg + 8'h01 >= n_target) begin
          active_next = cfg_i.gt ? (acc_sum > limit) : (acc_sum < limit);
          acc_next    = 24'h000000;
          n_next      = 8'h00;
        end else begin
          acc_next = acc_sum;
          n_next   = n_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg   <= 14'h0000;
      primed_reg <= 1'b0;
      acc_reg    <= 24'h000000;
      n_reg      <= 8'h00;
      active_reg <= 1'b0;
    end else begin
      prev_reg   <= prev_next;
      primed_reg <= primed_next;
      acc_reg    <= acc_next;
      n_reg      <= n_next;
      active_reg <= active_next;
    end
  end

  assign active_o = active_reg;

endmodule

`default_nettype wire

// ===== sim/alarm_offset_command_logic_assertions.sv
// Port-level checker for the command, offset and alarm logic
`timescale 1ns/1ns
`default_nettype none
`include "alarm_offset_consts.svh"
module alarm_offset_command_logic_assertions
  import alarm_offset_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = 20
)(
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [5:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire offsets_t    offsets_o,
  input wire logic [11:0] dac_level_o,
  input wire logic        flash_busy_o,
  input wire logic        flash_commit_o,
  input wire logic        aux_line_one_oe_o,
  input wire logic        aux_line_two_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  int unsigned busy_cnt;
  logic        cmd_wr;
  assign cmd_wr = reg_wr_i && reg_addr_i == `ADDR_COMMAND;
  // Length of the current busy run
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) busy_cnt <= 0;
    else busy_cnt <= flash_busy_o ? busy_cnt + 1 : 0;
  end
  property p_rvalid; 1 |-> reg_rvalid_o == $past(reg_rd_i); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
  property p_rdata_hold; !reg_rvalid_o |-> $stable(reg_rdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_cmd_rd0; reg_rd_i && reg_addr_i == `ADDR_COMMAND |=> reg_rdata_o == 16'h0000;
  endproperty
  a_cmd_rd0: assert property (p_cmd_rd0) else $error("command read not zero");
  property p_busy_start; $rose(flash_busy_o) |-> $past(cmd_wr && reg_wdata_i[`CMD_FLASH]);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("backup without command");
  property p_busy_len; $fell(flash_busy_o) |-> busy_cnt == FLASH_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("backup length wrong");
  property p_commit; 1 |-> flash_commit_o == $fell(flash_busy_o); endproperty
  a_commit: assert property (p_commit) else $error("commit pulse misplaced");
  property p_dac; $changed(dac_level_o) |-> $past(cmd_wr && reg_wdata_i[`CMD_DAC_LATCH]);
  endproperty
  a_dac: assert property (p_dac) else $error("DAC moved without latch");
  property p_offs; $changed(offsets_o) |-> $past(reg_wr_i); endproperty
  a_offs: assert property (p_offs) else $error("offsets moved without write");
  property p_oe_excl; !(aux_line_one_oe_o && aux_line_two_oe_o); endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both lines driven");
  c_commit: cover property (flash_commit_o);
  c_line: cover property ($rose(aux_line_one_oe_o));
  c_dac: cover property ($changed(dac_level_o));
endmodule
bind alarm_offset_command_logic alarm_offset_command_logic_assertions
  #(.FLASH_CYCLES(FLASH_CYCLES)) i_chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .offsets_o(offsets_o), .dac_level_o(dac_level_o), .flash_busy_o(flash_busy_o),
  .flash_commit_o(flash_commit_o), .aux_line_one_oe_o(aux_line_one_oe_o),
  .aux_line_two_oe_o(aux_line_two_oe_o));
`default_nettype wire

// ===== sim/host_model.sv
// Host model on the byte-wide register port
`timescale 1ns/1ns
`default_nettype none
module host_model #(
  parameter int FL = 20
)(
  input  wire logic        clock_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [5:0]       addr_o,
  output logic [7:0]       wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i
);
  initial begin
    wr_o = 1'h0;
    rd_o = 1'h0;
    addr_o = 6'h00;
    wdata_o = 8'h00;
  end
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock_i);
    wr_o = 1'h1;
    addr_o = a;
    wdata_o = d;
    @(negedge clock_i);
    wr_o = 1'h0;
    wdata_o = ~d;
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(a | 6'h01, d[15:8]);
  endtask
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    @(negedge clock_i);
    rd_o = 1'h1;
    addr_o = a;
    @(negedge clock_i);
    rd_o = 1'h0;
    d = rvalid_i ? rdata_i : 16'hXXXX;
  endtask
  task automatic clr;
    wr8(6'h3E, 8'h10);
  endtask
  // Backup, wait it out, check the error flag, retry once
  task automatic backup(output logic [15:0] st);
    for (int t = 0; t < 2; t++) begin
      wr8(6'h3E, 8'h08);
      repeat (FL + 4) @(negedge clock_i);
      rd16(6'h3C, st);
      if (!st[2]) break;
    end
  endtask
endmodule
`default_nettype wire

// ===== sim/alarm_offset_command_logic_tb.sv
// Self-checking bench for the command, offset and alarm logic
`timescale 1ns/1ns
`default_nettype none
`include "alarm_offset_consts.svh"
module alarm_offset_command_logic_tb
  import alarm_offset_pkg::*;
;
  localparam int FL = 20;
  logic        clock_i, resetn_i, wr, rd, sv, ff, rv, busy, commit, a1, a1e, a2, a2e;
  logic [5:0]  addr;
  logic [7:0]  wd;
  logic [15:0] rdat, d, v;
  logic [13:0] n;
  logic [11:0] dac;
  sample_t     outd, rawd;
  offsets_t    offs;
  flash_image_t img;
  int          error_cnt, tests_run, seed;
  logic [5:0]  ra[10] = '{6'h10, 6'h12, 6'h14, 6'h16, 6'h18, 6'h20, 6'h22, 6'h24, 6'h26, 6'h28};
  logic [15:0] rm[10] = '{16'h3FFF, 16'h3FFF, 16'h3FFF, 16'h3FFF, 16'h3FFF, 16'hBFFF,
                          16'hBFFF, 16'h00FF, 16'h00FF, 16'hFF7F};
  int          fk[5] = '{1, 2, 5, 6, 7};
  logic [15:0] mdl[10];
  host_model #(.FL(FL)) i_host_model (.clock_i(clock_i), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wd), .rdata_i(rdat), .rvalid_i(rv));
  alarm_offset_command_logic #(.FLASH_CYCLES(FL)) i_alarm_offset_command_logic (
    .clock_i(clock_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .sample_valid_i(sv), .out_data_i(outd), .raw_data_i(rawd), .flash_fail_i(ff),
    .offsets_o(offs), .dac_level_o(dac), .flash_busy_o(busy), .flash_commit_o(commit),
    .flash_image_o(img), .aux_line_one_o(a1), .aux_line_one_oe_o(a1e), .aux_line_two_o(a2),
    .aux_line_two_oe_o(a2e));
  initial begin
    clock_i = 1'h0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic smp;
    @(negedge clock_i);
    sv = 1'h1;
    @(negedge clock_i);
    sv = 1'h0;
    repeat (3) @(negedge clock_i);
  endtask
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {seed, error_cnt, tests_run} = {32'ha337, 64'h0};
    {resetn_i, sv, ff, outd, rawd} = '0;
    repeat (5) @(negedge clock_i);
    resetn_i = 1'h1;
    repeat (3) @(negedge clock_i);
    for (int i = 0; i < 10; i++) begin
      i_host_model.rd16(ra[i], d);
      chk(d, (i == 7 || i == 8) ? 16'h0001 : 16'h0000);
      v = 16'($random(seed));
      mdl[i] = v & rm[i];
      i_host_model.wr16(ra[i], v);
      i_host_model.rd16(ra[i], d);
      chk(d, mdl[i]);
    end
    for (int i = 0; i < 8; i++) outd[i * 14 +: 14] = 14'($random(seed));
    for (int j = 0; j < 2; j++) begin
      i_host_model.wr8(`ADDR_COMMAND, 8'h01 << j);
      for (int i = 0; i < 5; i++) begin
        n = (j == 0) ? 14'h0 - outd[(7 - fk[i]) * 14 +: 14] : 14'h0;
        i_host_model.rd16(ra[i], d);
        chk(d, {2'h0, n});
        chk({2'h0, offs[(4 - i) * 14 +: 14]}, {2'h0, n});
      end
    end
    i_host_model.wr16(`ADDR_AUX_DAC, 16'h0ABC);
    chk(16'(dac), 16'h0000);
    i_host_model.wr8(`ADDR_COMMAND, 8'h04);
    @(negedge clock_i);
    chk(16'(dac), 16'h0ABC);
    i_host_model.rd16(`ADDR_COMMAND, d);
    chk(d, 16'h0000);
    ff = 1'h1;
    i_host_model.wr8(`ADDR_COMMAND, 8'h08);
    chk(16'(busy), 16'h0001);
    i_host_model.wr8(`ADDR_COMMAND, 8'h08);
    for (int i = 0; i < FL + 5 && commit !== 1'h1; i++) @(negedge clock_i);
    ff = 1'h0;
    chk(16'(commit), 16'h0001);
    i_host_model.wr8(`ADDR_COMMAND, 8'h08);
    chk(16'(busy), 16'h0000);
    for (int i = 0; i < 2; i++) begin
      i_host_model.rd16(`ADDR_STATUS, d);
      chk(d & 16'h0004, i == 0 ? 16'h0004 : 16'h0000);
    end
    i_host_model.backup(d);
    chk(d & 16'h0004, 16'h0000);
    chk(16'(img === {70'h0, mdl[5], mdl[6], mdl[7][7:0], mdl[8][7:0], mdl[9]}),
        16'h0001);
    i_host_model.wr16(`ADDR_ALM2_THRESH, 16'h800A);
    for (int c = 1; c <= 8; c++) begin
      rawd = {8{14'h3FFB}};
      outd = rawd;
      rawd[(8 - c) * 14 +: 14] = 14'h0032;
      if (!(c inside {3, 6, 7})) outd = rawd;
      i_host_model.wr16(`ADDR_ALARM_CONTROL, 16'h0000);
      i_host_model.clr();
      i_host_model.wr16(`ADDR_ALARM_CONTROL, {4'(c), 7'h00, 1'(c == 3), 4'h0});
      smp();
      i_host_model.rd16(`ADDR_STATUS, d);
      chk(d & 16'h0200, (c inside {3, 6, 7}) ? 16'h0 : 16'h0200);
    end
    i_host_model.wr16(`ADDR_ALM1_THRESH, 16'h800A);
    i_host_model.wr16(`ADDR_ALM1_COUNT, 16'h0002);
    i_host_model.wr16(`ADDR_ALARM_CONTROL, 16'h0226);
    i_host_model.clr();
    for (int k = 0; k < 3; k++) begin
      rawd.x_accel = 14'(30 * k);
      smp();
      i_host_model.rd16(`ADDR_STATUS, d);
      chk(d & 16'h0100, k == 2 ? 16'h0100 : 16'h0);
    end
    chk({13'h0, a1, a1e, a2e}, 16'h0006);
    i_host_model.wr8(`ADDR_ALARM_CONTROL, 8'h25);
    repeat (2) @(negedge clock_i);
    chk({13'h0, a2, a2e, a1e}, 16'h0002);
    summarize();
  end
endmodule
`default_nettype wire
